// file: src/efpc_pkg.sv
package efpc_pkg;

  // register offsets, byte addresses on the bus
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0C;
  localparam logic [7:0] OFS_TRIG = 8'h10;
  localparam logic [7:0] OFS_DFBASE = 8'h14;
  localparam logic [7:0] OFS_KEY = 8'h20;
  localparam logic [7:0] OFS_CLKG = 8'h24;

  // flash map
  localparam logic [31:0] APP_BYTES = 32'h0001_0000;
  localparam logic [31:0] DF_BASE = 32'h0001_F000;
  localparam logic [31:0] LDR_BASE = 32'h0010_0000;
  localparam logic [31:0] CFG_ADDR = 32'h0030_0000;
  localparam int unsigned REGION_BITS = 12;
  localparam int unsigned PAGE_BITS = 9;

  // unlock sequence
  localparam logic [7:0] KEY0 = 8'h59;
  localparam logic [7:0] KEY1 = 8'h16;
  localparam logic [7:0] KEY2 = 8'h88;

  // operation codes
  localparam logic [3:0] OP_READ = 4'h0;
  localparam logic [3:0] OP_PROG = 4'h1;
  localparam logic [3:0] OP_ERASE = 4'h2;
  localparam logic [3:0] OP_ID = 4'hB;

  // field positions
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_BS_BIT = 1;
  localparam int unsigned CTRL_FF_BIT = 6;
  localparam int unsigned CTRL_SWRST_BIT = 7;
  localparam int unsigned CMD_CEN_BIT = 4;
  localparam int unsigned CMD_OEN_BIT = 5;
  localparam int unsigned CLKG_BIT = 2;
  localparam int unsigned CFG_LOCK_BIT = 1;
  localparam int unsigned CFG_BOOT_BIT = 7;

  // reset values
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  localparam logic [5:0] CMD_RST = 6'h00;

  // timing
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned PROG_TIME_NS = 40000;
  localparam int unsigned ERASE_TIME_US = 20000;
  localparam int unsigned PROG_CYC = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned ERASE_CYC = ERASE_TIME_US * CLK_MHZ;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic [3:0] op;
    logic [21:0] addr;
    logic [31:0] wdata;
  } efpc_flash_t;

  typedef enum logic [1:0] {SRC_CPU, SRC_CFG, SRC_ISP} efpc_src_t;

  typedef struct packed {
    logic vld;
    logic err;
    efpc_src_t src;
  } efpc_tag_t;

endpackage

// file: src/efpc_op_timer.sv
`timescale 1ns/10ps
module efpc_op_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [23:0] load_i,
  output logic done_o
);
  logic [23:0] cnt_r;
  logic run_r;
  logic done_r;

  // counts load_i cycles, then one done pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 24'h00_0000;
      run_r <= 1'h0;
      done_r <= 1'h0;
    end else begin
      done_r <= 1'h0;
      if (start_i) begin
        cnt_r <= load_i;
        run_r <= 1'h1;
      end else if (run_r) begin
        if (cnt_r <= 24'h00_0001) begin
          run_r <= 1'h0;
          done_r <= 1'h1;
        end else begin
          cnt_r <= cnt_r - 24'h00_0001;
        end
      end
    end
  end

  assign done_o = done_r;
endmodule

// file: src/efpc_flash_ctrl.sv
// Notes on behaviour
// - 4KB data region sits at 0x0001_F000 after the application region.
// - 4KB loader region spans 0x0010_0000 to 0x0010_0FFF.
// - one config word at 0x0030_0000 acts as fuses.
// - config word is read from flash into control state at power-on.
// - page erase works on 512-byte aligned pages.
// - boot source follows the config boot bit after power-on.
// - software sets boot-from-loader and resets to boot the loader.
// - control writes take effect only after keys 59,16,88 in order.
// - trigger checks errors; on error no start, fail flag set.
// - fail flag sticks until cleared; new operations still run.
// - CPU is stalled while an operation runs.
// - interrupts are held off until the operation ends.
// - config erase refused unless application page erased before.
// - op decoded from two low enables plus a 4-bit code.
// - A20 picks loader; A21 and A20 high pick config.
// - sequential reads pipelined, one per cycle, no wait states.
// - program takes data register; read and id return into it.
// - trigger reads 1 while busy, clears itself on completion.
// - programming addresses must keep bits 1:0 at zero.
`timescale 1ns/10ps
module efpc_flash_ctrl import efpc_pkg::*; #(
  parameter int unsigned PROG_CYCLES = PROG_CYC,
  parameter int unsigned ERASE_CYCLES = ERASE_CYC,
  // arbitrary maker code
  parameter logic [31:0] MAKER_ID = 32'h0000_005C
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cpu_req_i,
  input wire logic [21:0] cpu_addr_i,
  output logic [31:0] cpu_rdata_o,
  output logic cpu_rvalid_o,
  output logic cpu_err_o,
  output logic cpu_stall_o,
  output logic irq_hold_o,
  output logic boot_from_loader_o,
  output logic [31:0] cfg_word_o,
  output logic sec_lock_o,
  output logic sw_reset_o,
  output efpc_flash_t flash_o,
  input wire logic [31:0] flash_rdata_i
);
  typedef enum logic [2:0] {
    ST_CFG, ST_WAIT, ST_IDLE, ST_CHECK, ST_RD, ST_OP, ST_DONE
  } efpc_state_t;

  efpc_state_t state_r, st_nxt;
  efpc_flash_t flash_r, flash_nxt;
  efpc_tag_t tag1_r, tag2_r, tag1_nxt;
  logic ack_r, en_r, bs_r, fail_r, swrst_r, trig_r, clkg_r;
  logic app_erased_r, stall_r, rvalid_r, rerr_r, lock_r;
  logic [31:0] dat_r, addr_r, data_r, cfg_r, rdata_r, rd_mux;
  logic [5:0] cmd_r;
  logic [1:0] key_r;

  function automatic logic [31:0] bmerge(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      bmerge[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
    end
  endfunction

  function automatic logic region_ok(input logic [31:0] a);
    logic app, dfl, ldr, cfg;
    app = a < APP_BYTES;
    dfl = a[31:REGION_BITS] == DF_BASE[31:REGION_BITS];
    ldr = a[31:REGION_BITS] == LDR_BASE[31:REGION_BITS];
    cfg = a[31:2] == CFG_ADDR[31:2];
    region_ok = app | dfl | ldr | cfg;
  endfunction

  // bus decode
  wire wb_req = wb_cyc_i & wb_stb_i & ~ack_r;
  wire wr = wb_req & wb_we_i;
  wire unlocked = key_r == 2'h3;
  wire wr_ctrl = wr & (wb_adr_i == OFS_CTRL) & unlocked;
  wire wr_addr = wr & (wb_adr_i == OFS_ADDR) & ~trig_r;
  wire wr_data = wr & (wb_adr_i == OFS_DATA) & ~trig_r;
  wire wr_cmd = wr & (wb_adr_i == OFS_CMD) & ~trig_r & wb_sel_i[0];
  wire wr_key = wr & (wb_adr_i == OFS_KEY) & wb_sel_i[0];
  wire wr_clkg = wr & (wb_adr_i == OFS_CLKG) & wb_sel_i[0];
  wire start = wr & (wb_adr_i == OFS_TRIG) & wb_sel_i[0] & wb_dat_i[0]
               & (state_r == ST_IDLE);
  wire clr_fail = wr_ctrl & wb_sel_i[0] & wb_dat_i[CTRL_FF_BIT];

  // operation decode
  wire [1:0] ens_n = {cmd_r[CMD_OEN_BIT], cmd_r[CMD_CEN_BIT]};
  wire [3:0] code = cmd_r[3:0];
  wire is_stby = ens_n == 2'h3;
  wire is_id = (ens_n == 2'h0) & (code == OP_ID);
  wire is_rd = (ens_n == 2'h0) & (code == OP_READ);
  wire is_pg = (ens_n == 2'h2) & (code == OP_PROG);
  wire is_er = (ens_n == 2'h2) & (code == OP_ERASE);
  wire a_cfg = addr_r[21] & addr_r[20];
  wire app_hit = addr_r < APP_BYTES;
  wire needs_addr = is_rd | is_pg | is_er;
  wire addr_bad = (addr_r[1:0] != 2'h0) | ~region_ok(addr_r);
  wire cfg_erase_bad = is_er & a_cfg & ~app_erased_r;
  wire chk_err = ~en_r | ~clkg_r
                 | (needs_addr & addr_bad)
                 | ~(is_stby | is_id | needs_addr)
                 | cfg_erase_bad;
  wire op_go = (state_r == ST_CHECK) & ~chk_err & (is_pg | is_er);
  wire [23:0] op_len = is_er ? 24'(ERASE_CYCLES) : 24'(PROG_CYCLES);
  wire op_done;
  wire cpu_acc = cpu_req_i & ~stall_r;
  wire cpu_bad = ~region_ok({10'h000, cpu_addr_i});
  wire key_hit = wb_dat_i[7:0] == (key_r == 2'h0 ? KEY0 :
                 key_r == 2'h1 ? KEY1 : KEY2);

  efpc_op_timer u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(op_go),
    .load_i(op_len),
    .done_o(op_done)
  );

  always_comb begin
    rd_mux = REG_RST;
    if (wb_adr_i == OFS_CTRL) begin
      rd_mux = {24'h00_0000, 1'h0, fail_r, 4'h0, bs_r, en_r};
    end else if (wb_adr_i == OFS_ADDR) begin
      rd_mux = addr_r;
    end else if (wb_adr_i == OFS_DATA) begin
      rd_mux = data_r;
    end else if (wb_adr_i == OFS_CMD) begin
      rd_mux = {26'h000_0000, cmd_r};
    end else if (wb_adr_i == OFS_TRIG) begin
      rd_mux = {31'h0000_0000, trig_r};
    end else if (wb_adr_i == OFS_DFBASE) begin
      rd_mux = DF_BASE;
    end else if (wb_adr_i == OFS_KEY) begin
      rd_mux = {31'h0000_0000, unlocked};
    end else if (wb_adr_i == OFS_CLKG) begin
      rd_mux = {29'h0000_0000, clkg_r, 2'h0};
    end
  end

  always_comb begin
    st_nxt = state_r;
    case (state_r)
      ST_CFG: st_nxt = ST_WAIT;
      ST_WAIT: begin
        if (tag2_r.vld && tag2_r.src == SRC_CFG) begin
          st_nxt = ST_IDLE;
        end else if (tag2_r.vld && tag2_r.src == SRC_ISP) begin
          st_nxt = ST_DONE;
        end
      end
      ST_IDLE: begin
        if (start) begin
          st_nxt = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (chk_err || is_stby || is_id) begin
          st_nxt = ST_DONE;
        end else if (is_rd) begin
          st_nxt = ST_RD;
        end else begin
          st_nxt = ST_OP;
        end
      end
      ST_RD: st_nxt = ST_WAIT;
      ST_OP: begin
        if (op_done) begin
          st_nxt = ST_DONE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  // flash port: one driver, ISP work wins over CPU fetch
  always_comb begin
    flash_nxt = '{ce_n: 1'h1, oe_n: 1'h1, op: OP_READ,
                  addr: 22'h00_0000, wdata: REG_RST};
    tag1_nxt = '{vld: 1'h0, err: 1'h0, src: SRC_CPU};
    if (state_r == ST_CFG) begin
      flash_nxt.ce_n = 1'h0;
      flash_nxt.oe_n = 1'h0;
      flash_nxt.addr = CFG_ADDR[21:0];
      tag1_nxt = '{vld: 1'h1, err: 1'h0, src: SRC_CFG};
    end else if (state_r == ST_RD) begin
      flash_nxt.ce_n = 1'h0;
      flash_nxt.oe_n = 1'h0;
      flash_nxt.addr = addr_r[21:0];
      tag1_nxt = '{vld: 1'h1, err: 1'h0, src: SRC_ISP};
    end else if (state_r == ST_OP) begin
      flash_nxt.ce_n = 1'h0;
      flash_nxt.op = code;
      flash_nxt.addr = addr_r[21:0];
      if (is_er) begin
        flash_nxt.addr[PAGE_BITS-1:0] = '0;
      end
      flash_nxt.wdata = data_r;
    end else if (cpu_acc) begin
      flash_nxt.ce_n = cpu_bad;
      flash_nxt.oe_n = cpu_bad;
      flash_nxt.addr = cpu_addr_i;
      tag1_nxt = '{vld: 1'h1, err: cpu_bad, src: SRC_CPU};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_CFG;
      flash_r <= '{ce_n: 1'h1, oe_n: 1'h1, op: OP_READ,
                   addr: 22'h00_0000, wdata: REG_RST};
      tag1_r <= '{vld: 1'h0, err: 1'h0, src: SRC_CPU};
      tag2_r <= '{vld: 1'h0, err: 1'h0, src: SRC_CPU};
      stall_r <= 1'h1;
    end else begin
      state_r <= st_nxt;
      flash_r <= flash_nxt;
      tag1_r <= tag1_nxt;
      tag2_r <= tag1_r;
      stall_r <= st_nxt != ST_IDLE;
    end
  end

  // read return, captured two cycles after issue
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rvalid_r <= 1'h0;
      rerr_r <= 1'h0;
      rdata_r <= REG_RST;
      cfg_r <= REG_RST;
      lock_r <= 1'h0;
    end else begin
      rvalid_r <= tag2_r.vld & (tag2_r.src == SRC_CPU);
      rerr_r <= tag2_r.vld & (tag2_r.src == SRC_CPU) & tag2_r.err;
      if (tag2_r.vld && tag2_r.src == SRC_CPU) begin
        rdata_r <= tag2_r.err ? REG_RST : flash_rdata_i;
      end
      if (tag2_r.vld && tag2_r.src == SRC_CFG) begin
        cfg_r <= flash_rdata_i;
        lock_r <= ~flash_rdata_i[CFG_LOCK_BIT];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'h0;
      dat_r <= REG_RST;
    end else begin
      ack_r <= wb_req;
      dat_r <= rd_mux;
    end
  end

  // control register and unlock sequence
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key_r <= 2'h0;
      en_r <= 1'h0;
      bs_r <= 1'h0;
      swrst_r <= 1'h0;
      clkg_r <= 1'h0;
    end else begin
      swrst_r <= 1'h0;
      if (wr_key) begin
        if (key_r != 2'h3 && key_hit) begin
          key_r <= key_r + 2'h1;
        end else begin
          key_r <= (wb_dat_i[7:0] == KEY0) ? 2'h1 : 2'h0;
        end
      end
      if (tag2_r.vld && tag2_r.src == SRC_CFG) begin
        bs_r <= ~flash_rdata_i[CFG_BOOT_BIT];
      end else if (wr_ctrl && wb_sel_i[0]) begin
        en_r <= wb_dat_i[CTRL_EN_BIT];
        bs_r <= wb_dat_i[CTRL_BS_BIT];
        swrst_r <= wb_dat_i[CTRL_SWRST_BIT];
      end
      if (wr_clkg) begin
        clkg_r <= wb_dat_i[CLKG_BIT];
      end
    end
  end

  // operation registers, trigger and fail flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_r <= REG_RST;
      data_r <= REG_RST;
      cmd_r <= CMD_RST;
      trig_r <= 1'h0;
      fail_r <= 1'h0;
      app_erased_r <= 1'h0;
    end else begin
      if (wr_addr) begin
        addr_r <= bmerge(addr_r, wb_dat_i, wb_sel_i);
      end
      if (wr_cmd) begin
        cmd_r <= wb_dat_i[5:0];
      end
      if (wr_data) begin
        data_r <= bmerge(data_r, wb_dat_i, wb_sel_i);
      end else if (state_r == ST_CHECK && !chk_err && is_id) begin
        data_r <= MAKER_ID;
      end else if (tag2_r.vld && tag2_r.src == SRC_ISP) begin
        data_r <= flash_rdata_i;
      end
      if (start) begin
        trig_r <= 1'h1;
      end else if (state_r == ST_DONE) begin
        trig_r <= 1'h0;
      end
      if (state_r == ST_CHECK && chk_err) begin
        fail_r <= 1'h1;
      end else if (clr_fail) begin
        fail_r <= 1'h0;
      end
      if (op_go && is_er && app_hit) begin
        app_erased_r <= 1'h1;
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign cpu_rdata_o = rdata_r;
  assign cpu_rvalid_o = rvalid_r;
  assign cpu_err_o = rerr_r;
  assign cpu_stall_o = stall_r;
  assign irq_hold_o = stall_r;
  assign boot_from_loader_o = bs_r;
  assign cfg_word_o = cfg_r;
  assign sec_lock_o = lock_r;
  assign sw_reset_o = swrst_r;
  assign flash_o = flash_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_key_gate;
    wr & (wb_adr_i == OFS_CTRL) & ~unlocked |=> $stable(en_r);
  endproperty
  a_key_gate: assert property (p_key_gate)
    else $error("control written while locked");

  property p_err_fail;
    (state_r == ST_CHECK) && chk_err |=> fail_r ##1 !trig_r;
  endproperty
  a_err_fail: assert property (p_err_fail)
    else $error("error did not set fail or end op");

  property p_fail_sticky;
    fail_r && !clr_fail |=> fail_r;
  endproperty
  a_fail_sticky: assert property (p_fail_sticky)
    else $error("fail flag lost");

  property p_stall;
    trig_r |-> cpu_stall_o && irq_hold_o;
  endproperty
  a_stall: assert property (p_stall)
    else $error("cpu not held while busy");

  property p_trig_clear;
    state_r == ST_DONE |=> !trig_r && !cpu_stall_o;
  endproperty
  a_trig_clear: assert property (p_trig_clear)
    else $error("trigger not cleared");

  property p_busy_hold;
    trig_r && !start |=> $stable(addr_r) && $stable(cmd_r);
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("op registers changed while busy");

  property p_cfg_erase;
    (state_r == ST_CHECK) && is_er && a_cfg && !app_erased_r
      |=> state_r == ST_DONE && fail_r;
  endproperty
  a_cfg_erase: assert property (p_cfg_erase)
    else $error("config erase not refused");

  property p_rd_lat;
    cpu_acc |-> ##3 cpu_rvalid_o;
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("cpu read not returned in three cycles");

  property p_align;
    state_r == ST_OP |=> flash_o.addr[1:0] == 2'h0 && !flash_o.ce_n;
  endproperty
  a_align: assert property (p_align)
    else $error("unaligned programming address");

  property p_page;
    state_r == ST_OP && is_er |=> flash_o.addr[8:0] == 9'h000;
  endproperty
  a_page: assert property (p_page)
    else $error("erase not page aligned");

  c_prog: cover property (op_go && is_pg);
  c_erase: cover property (op_go && is_er);
  c_fail: cover property ((state_r == ST_CHECK) && chk_err);
  c_isp_read: cover property (state_r == ST_RD ##3 state_r == ST_DONE);
endmodule

// file: sim/efpc_flash_model.sv
`timescale 1ns/10ps
module efpc_flash_model import efpc_pkg::*; #(
  parameter logic [31:0] CFG_INIT = 32'h1234_5682
) (
  input wire logic clk_i,
  input wire efpc_flash_t flash_i,
  output logic [31:0] rdata_o
);
  logic [31:0] mem [logic [19:0]];
  wire [19:0] widx = flash_i.addr[21:2];
  wire sel = !flash_i.ce_n;
  wire rd = sel && !flash_i.oe_n && flash_i.op == OP_READ;
  wire pg = sel && flash_i.oe_n && flash_i.op == OP_PROG;
  wire er = sel && flash_i.oe_n && flash_i.op == OP_ERASE;

  function automatic logic [31:0] look(input logic [19:0] w);
    return mem.exists(w) ? mem[w] : 32'hFFFF_FFFF;
  endfunction

  initial begin
    mem[CFG_ADDR[21:2]] = CFG_INIT;
    rdata_o = 32'h0000_0000;
  end

  always @(posedge clk_i) begin
    if (rd) begin
      rdata_o <= look(widx);
    end else begin
      // released bus: no stale value left to lean on
      rdata_o <= ~rdata_o;
    end
    if (pg) begin
      mem[widx] = look(widx) & flash_i.wdata;
    end
    if (er) begin
      // one page is 128 words
      for (int i = 0; i < 128; i++) begin
        mem[{widx[19:7], i[6:0]}] = 32'hFFFF_FFFF;
      end
    end
  end
endmodule

// file: sim/tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
  bad_count++; $display("mismatch at %0t: got %h expected %h", \
  $time, g, e); end end
module tb import efpc_pkg::*;;
  localparam logic [31:0] CFG_INIT = 32'h1234_5682;
  localparam logic [31:0] MID = 32'h0000_005C;
  logic clk_i, rst_i, cyc, wwe, req, lk_sw, stall_seen, busy1;
  logic [7:0] adr;
  logic [31:0] wdat, wb_dat_o, cpu_rdata_o, cfg_word_o, frd;
  logic [21:0] cadr;
  logic wb_ack_o, cpu_rvalid_o, cpu_err_o, cpu_stall_o, irq_hold_o;
  logic boot_from_loader_o, sec_lock_o, sw_reset_o;
  efpc_flash_t flash;
  logic [31:0] rq[$];
  logic eq[$];
  int tq[$];
  int bad_count, tests_run, cyc_cnt;

  efpc_flash_ctrl #(.PROG_CYCLES(8), .ERASE_CYCLES(20), .MAKER_ID(MID)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(wwe), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpu_req_i(req),
    .cpu_addr_i(cadr), .cpu_rdata_o(cpu_rdata_o),
    .cpu_rvalid_o(cpu_rvalid_o), .cpu_err_o(cpu_err_o),
    .cpu_stall_o(cpu_stall_o), .irq_hold_o(irq_hold_o),
    .boot_from_loader_o(boot_from_loader_o), .cfg_word_o(cfg_word_o),
    .sec_lock_o(sec_lock_o), .sw_reset_o(sw_reset_o), .flash_o(flash),
    .flash_rdata_i(frd));

  efpc_flash_model #(.CFG_INIT(CFG_INIT)) flash_mdl (
    .clk_i(clk_i), .flash_i(flash), .rdata_o(frd));

  always #4 clk_i = ~clk_i;

  always @(negedge clk_i) begin
    if (cpu_stall_o === 1'b1 && irq_hold_o === 1'b1) stall_seen = 1'b1;
    if (sw_reset_o === 1'b1) lk_sw = 1'b1;
    if (cpu_rvalid_o === 1'b1) begin
      rq.push_back(cpu_rdata_o);
      eq.push_back(cpu_err_o);
      tq.push_back(cyc_cnt);
    end
  end

  task automatic finish_test();
    $display("counts: tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    wwe <= we;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0;
    wwe <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, q);
    `CHK(q, e)
  endtask

  // poke writes the address register while the operation runs
  task automatic isp(input logic [5:0] c, input logic [31:0] a,
                     input logic [31:0] d, input logic poke);
    logic [31:0] q;
    int n;
    n = 0;
    wr(OFS_ADDR, a);
    wr(OFS_DATA, d);
    wr(OFS_CMD, {26'h0, c});
    stall_seen = 1'b0;
    wr(OFS_TRIG, 32'h0000_0001);
    if (poke) wr(OFS_ADDR, ~a);
    wb(1'b0, OFS_TRIG, 32'h0000_0000, q);
    busy1 = q[0];
    while (q[0] !== 1'b0 && n < 200) begin
      wb(1'b0, OFS_TRIG, 32'h0000_0000, q);
      n++;
    end
    `CHK(q[0], 1'b0)
  endtask

  task automatic fetch3(input logic [21:0] a0, a1, a2);
    rq.delete();
    eq.delete();
    tq.delete();
    @(posedge clk_i);
    req <= 1'b1;
    cadr <= a0;
    @(posedge clk_i);
    cadr <= a1;
    @(posedge clk_i);
    cadr <= a2;
    @(posedge clk_i);
    req <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask

  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    {cyc, wwe, req, lk_sw, stall_seen, busy1} = '0;
    adr = 8'h00;
    wdat = 32'h0000_0000;
    cadr = 22'h00_0000;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (40) @(posedge clk_i);
    `CHK(cfg_word_o, CFG_INIT)
    `CHK(boot_from_loader_o, 1'b0)
    `CHK(sec_lock_o, 1'b0)
    rd(OFS_DFBASE, DF_BASE);
    rd(OFS_CTRL, REG_RST);
    rd(8'h30, 32'h0000_0000);
    $display("test reset done");

    wr(OFS_CTRL, 32'h0000_0001);
    rd(OFS_CTRL, 32'h0000_0000);
    wr(OFS_KEY, 32'h0000_0016);
    wr(OFS_KEY, 32'h0000_0059);
    wr(OFS_KEY, 32'h0000_0088);
    rd(OFS_KEY, 32'h0000_0000);
    wr(OFS_KEY, {24'h0, KEY0});
    wr(OFS_KEY, {24'h0, KEY1});
    wr(OFS_KEY, {24'h0, KEY2});
    rd(OFS_KEY, 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_0001);
    rd(OFS_CTRL, 32'h0000_0001);
    $display("test unlock done");

    isp(6'h21, 32'h0001_F000, 32'h0000_0000, 1'b0);
    rd(OFS_CTRL, 32'h0000_0041);
    wr(OFS_CTRL, 32'h0000_0041);
    rd(OFS_CTRL, 32'h0000_0001);
    wr(OFS_CLKG, 32'h0000_0004);
    $display("test error done");

    isp(6'h21, 32'h0001_F004, 32'hA5A5_1234, 1'b1);
    `CHK(busy1, 1'b1)
    `CHK(stall_seen, 1'b1)
    rd(OFS_ADDR, 32'h0001_F004);
    rd(OFS_TRIG, 32'h0000_0000);
    isp(6'h00, 32'h0001_F004, 32'h0000_0000, 1'b0);
    rd(OFS_DATA, 32'hA5A5_1234);
    isp(6'h21, 32'h0010_0008, 32'h0BAD_F00D, 1'b0);
    fetch3(22'h01_F004, 22'h10_0008, 22'h02_0000);
    `CHK(rq.size(), 3)
    `CHK(tq[2] - tq[0], 2)
    `CHK(rq[0], 32'hA5A5_1234)
    `CHK(rq[1], 32'h0BAD_F00D)
    `CHK({eq[0], eq[1], eq[2]}, 3'b001)
    $display("test program done");

    isp(6'h21, 32'h0001_F006, 32'h0000_0000, 1'b0);
    rd(OFS_CTRL, 32'h0000_0041);
    isp(6'h21, 32'h0001_F008, 32'h0000_5A5A, 1'b0);
    rd(OFS_CTRL, 32'h0000_0041);
    isp(6'h00, 32'h0001_F008, 32'h0000_0000, 1'b0);
    rd(OFS_DATA, 32'h0000_5A5A);
    wr(OFS_CTRL, 32'h0000_0041);
    isp(6'h0B, 32'h0000_0000, 32'h0000_0000, 1'b0);
    rd(OFS_DATA, MID);
    isp(6'h30, 32'h0000_0000, 32'h0000_0000, 1'b0);
    rd(OFS_CTRL, 32'h0000_0001);
    isp(6'h03, 32'h0000_0000, 32'h0000_0000, 1'b0);
    rd(OFS_CTRL, 32'h0000_0041);
    wr(OFS_CTRL, 32'h0000_0041);
    $display("test codes done");

    isp(6'h22, CFG_ADDR, 32'h0000_0000, 1'b0);
    rd(OFS_CTRL, 32'h0000_0041);
    wr(OFS_CTRL, 32'h0000_0041);
    isp(6'h22, 32'h0001_F010, 32'h0000_0000, 1'b0);
    isp(6'h00, 32'h0001_F008, 32'h0000_0000, 1'b0);
    rd(OFS_DATA, 32'hFFFF_FFFF);
    isp(6'h22, 32'h0000_0000, 32'h0000_0000, 1'b0);
    isp(6'h22, CFG_ADDR, 32'h0000_0000, 1'b0);
    rd(OFS_CTRL, 32'h0000_0001);
    isp(6'h00, CFG_ADDR, 32'h0000_0000, 1'b0);
    rd(OFS_DATA, 32'hFFFF_FFFF);
    $display("test erase done");

    wr(OFS_CTRL, 32'h0000_0083);
    repeat (3) @(posedge clk_i);
    `CHK(lk_sw, 1'b1)
    `CHK(boot_from_loader_o, 1'b1)
    $display("test boot done");
    finish_test();
  end
endmodule
